// ---- logic/sirq_cfg.svh ----
`ifndef SIRQ_CFG_SVH
`define SIRQ_CFG_SVH
`define SIRQ_AW 20
`define SIRQ_OFF_PRIO      20'h40263
`define SIRQ_OFF_PRIO1     20'h40264
`define SIRQ_OFF_ENABLE    20'h40276
`define SIRQ_OFF_FLAGS     20'h40286
`define SIRQ_OFF_ROUTE0    20'h40292
`define SIRQ_OFF_ROUTE1    20'h40293
`define SIRQ_OFF_CTRL      20'h402A0
`define SIRQ_OFF_STATUS    20'h402A1
`define SIRQ_IDX_ERR       0
`define SIRQ_IDX_RXF       1
`define SIRQ_IDX_TXE       2
`define SIRQ_CH_STRIDE     3
`define SIRQ_PRIO0_LSB     4
`define SIRQ_PRIO1_LSB     0
`define SIRQ_R0_RXF        6
`define SIRQ_R0_TXE        7
`define SIRQ_R1_RXF        0
`define SIRQ_R1_TXE        1
`define SIRQ_CTL_CLRONLY   0
`define SIRQ_CTL_PFS       1
`define SIRQ_CTL_TXEN0     2
`define SIRQ_CTL_RXEN0     3
`define SIRQ_CTL_TXEN1     4
`define SIRQ_CTL_RXEN1     5
`define SIRQ_CTL_MODE0     6
`define SIRQ_CTL_MODE1     8
`define SIRQ_CTL_RESET     10'h001
`define SIRQ_ENABLE_RESET  6'h00
`define SIRQ_FLAGS_RESET   6'h00
`define SIRQ_ROUTE_RESET   2'h0
`define SIRQ_PRIO_RESET    3'h0
`define SIRQ_MODE_MASTER   2'h0
`define SIRQ_MODE_SLAVE    2'h1
`endif

// ---- logic/sirq_pkg.sv ----
package sirq_pkg;
  typedef struct packed {
    logic err;
    logic rxf;
    logic txe;
  } sirq_evt_t;
  typedef struct packed {
    logic [1:0] o;
    logic [1:0] oe;
  } sirq_pin_t;
  typedef enum logic [2:0] {
    SIRQ_IDLE = 3'h1,
    SIRQ_REQ  = 3'h2,
    SIRQ_DMA  = 3'h4
  } sirq_st_t;
endpackage : sirq_pkg

// ---- logic/sirq_chan.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sirq_cfg.svh"
module sirq_chan (
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              srst_i,
  // Factor events and routing
  input  wire sirq_pkg::sirq_evt_t evt_i,
  input  wire logic [1:0]        route_i,
  input  wire logic              dma_done_i,
  input  wire logic              dma_end_irq_en_i,
  // Pending DMA request and per-factor gate toward the CPU side
  output logic                   dma_req_o,
  output logic [2:0]             ready_o
);
  import sirq_pkg::*;
  sirq_st_t   st_q;
  logic       rxf_via_dma;
  logic [1:0] done_q;
  assign rxf_via_dma = evt_i.rxf ? route_i[0] : 1'b0;
  // DMA handshake: request held until done, end interrupt permitted afterwards
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st_q <= SIRQ_IDLE;
    end else begin
      case (st_q)
        SIRQ_IDLE: if ((evt_i.rxf && route_i[0]) || (evt_i.txe && route_i[1])) st_q <= SIRQ_REQ;
        SIRQ_REQ:  if (dma_done_i) st_q <= SIRQ_DMA;
        SIRQ_DMA:  st_q <= SIRQ_IDLE;
        default:   st_q <= SIRQ_IDLE;
      endcase
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      dma_req_o <= 1'b0;
    end else begin
      dma_req_o <= (st_q == SIRQ_IDLE) ?
                   ((evt_i.rxf && route_i[0]) || (evt_i.txe && route_i[1])) :
                   ((st_q == SIRQ_REQ) && !dma_done_i);
    end
  end
  // Transfer end is remembered until the next factor, so a set flag keeps requesting
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      done_q <= 2'h0;
    end else begin
      if (st_q == SIRQ_DMA) begin
        done_q <= 2'h3;
      end else begin
        if (evt_i.rxf) begin
          done_q[0] <= 1'b0;
        end
        if (evt_i.txe) begin
          done_q[1] <= 1'b0;
        end
      end
    end
  end
  // Per-factor gate: routed factors pass only after the transfer and with end enable
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ready_o <= 3'h0;
    end else begin
      ready_o[`SIRQ_IDX_ERR] <= 1'b1;
      ready_o[`SIRQ_IDX_RXF] <= !route_i[0] || (((st_q == SIRQ_DMA) || (done_q[0] && !evt_i.rxf))
                                && dma_end_irq_en_i);
      ready_o[`SIRQ_IDX_TXE] <= !route_i[1] || (((st_q == SIRQ_DMA) || (done_q[1] && !evt_i.txe))
                                && dma_end_irq_en_i);
    end
  end
  logic unused_ok;
  assign unused_ok = rxf_via_dma;
endmodule : sirq_chan
`default_nettype wire

// ---- logic/sirq_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sirq_cfg.svh"
module sirq_top (
  // Clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   srst_i,
  // Avalon-MM slave
  input  wire logic [`SIRQ_AW-1:0]    avs_address_i,
  input  wire logic                   avs_read_i,
  input  wire logic                   avs_write_i,
  input  wire logic [31:0]            avs_writedata_i,
  input  wire logic [3:0]             avs_byteenable_i,
  output logic [31:0]                 avs_readdata_o,
  output logic                        avs_waitrequest_o,
  output logic [1:0]                  avs_response_o,
  // Datapath factor events per channel
  input  wire sirq_pkg::sirq_evt_t    evt0_i,
  input  wire sirq_pkg::sirq_evt_t    evt1_i,
  // CPU and DMA side
  input  wire logic                   cpu_interrupt_enable_i,
  input  wire logic [2:0]             cpu_interrupt_level_i,
  input  wire logic                   higher_req_pending_i,
  input  wire logic [1:0]             dma_done_i,
  input  wire logic [1:0]             dma_end_irq_en_i,
  output logic [1:0]                  dma_req_o,
  output logic [1:0]                  irq_req_o,
  output logic [2:0]                  irq_level_o,
  // Pin directions: bit0 channel 0, bit1 channel 1
  output sirq_pkg::sirq_pin_t         sync_ready_pin_o,
  output sirq_pkg::sirq_pin_t         serial_clock_pin_o,
  output logic [1:0]                  serial_data_in_pin_oe_o,
  output logic [1:0]                  serial_data_out_pin_oe_o
);
  import sirq_pkg::*;

  logic [5:0]  enable_q;
  logic [5:0]  flags_q;
  logic [1:0]  route0_q;
  logic [1:0]  route1_q;
  logic [2:0]  prio0_q;
  logic [2:0]  prio1_q;
  logic [9:0]  ctrl_q;
  logic        ack_q;
  logic [5:0]  set_evt;
  logic [5:0]  gate;
  logic [2:0]  ready0;
  logic [2:0]  ready1;
  logic [1:0]  dma_req;
  logic        wr;
  logic [7:0]  wb;
  logic [7:0]  rd_d;
  logic        hit;
  sirq_evt_t   ev0;
  sirq_evt_t   ev1;

  // Receive error forces receive full in the same cycle
  always_comb begin
    ev0 = evt0_i;
    ev1 = evt1_i;
    ev0.rxf = evt0_i.rxf | evt0_i.err;
    ev1.rxf = evt1_i.rxf | evt1_i.err;
  end
  // Factor bits per channel
  assign set_evt = {ev1.txe, ev1.rxf, ev1.err, ev0.txe, ev0.rxf, ev0.err};

  // Bus strobe: one wait cycle, answer on the second edge
  assign wr = avs_write_i && ack_q;
  assign wb = avs_writedata_i[7:0];
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read_i || avs_write_i) && !ack_q;
    end
  end
  always_comb begin
    avs_waitrequest_o = !ack_q;
  end

  // Interrupt enable register
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      enable_q <= `SIRQ_ENABLE_RESET;
    end else if (wr && avs_byteenable_i[0] && avs_address_i == `SIRQ_OFF_ENABLE) begin
      enable_q <= wb[5:0];
    end
  end

  // Factor flags: hardware sets, set wins over software clear
  generate
    for (genvar i = 0; i < 6; i++) begin : g_flag
      logic wsel;
      assign wsel = wr && avs_byteenable_i[0] && avs_address_i == `SIRQ_OFF_FLAGS;
      always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
          flags_q[i] <= 1'b0;
        end else if (set_evt[i]) begin
          flags_q[i] <= 1'b1;
        end else if (wsel) begin
          if (ctrl_q[`SIRQ_CTL_CLRONLY]) begin
            flags_q[i] <= flags_q[i] & ~wb[i];
          end else begin
            flags_q[i] <= wb[i];
          end
        end
      end
    end
  endgenerate

  // Route selections and priority levels
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      route0_q <= `SIRQ_ROUTE_RESET;
      route1_q <= `SIRQ_ROUTE_RESET;
    end else if (wr && avs_byteenable_i[0]) begin
      if (avs_address_i == `SIRQ_OFF_ROUTE0) begin
        route0_q <= {wb[`SIRQ_R0_TXE], wb[`SIRQ_R0_RXF]};
      end
      if (avs_address_i == `SIRQ_OFF_ROUTE1) begin
        route1_q <= {wb[`SIRQ_R1_TXE], wb[`SIRQ_R1_RXF]};
      end
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      prio0_q <= `SIRQ_PRIO_RESET;
      prio1_q <= `SIRQ_PRIO_RESET;
    end else if (wr && avs_byteenable_i[0]) begin
      if (avs_address_i == `SIRQ_OFF_PRIO) begin
        prio0_q <= wb[`SIRQ_PRIO0_LSB +: 3];
      end
      if (avs_address_i == `SIRQ_OFF_PRIO1) begin
        prio1_q <= wb[`SIRQ_PRIO1_LSB +: 3];
      end
    end
  end

  // Control: clear-only select, pin function, enables, modes
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ctrl_q <= `SIRQ_CTL_RESET;
    end else if (wr && avs_address_i == `SIRQ_OFF_CTRL) begin
      if (avs_byteenable_i[0]) begin
        ctrl_q[7:0] <= wb;
      end
      if (avs_byteenable_i[1]) begin
        ctrl_q[9:8] <= avs_writedata_i[9:8];
      end
    end
  end

  // DMA handshakes and interrupt gating per channel
  sirq_chan u_ch0 (
    .sys_clk_i        (sys_clk_i),
    .srst_i           (srst_i),
    .evt_i            (ev0),
    .route_i          (route0_q),
    .dma_done_i       (dma_done_i[0]),
    .dma_end_irq_en_i (dma_end_irq_en_i[0]),
    .dma_req_o        (dma_req[0]),
    .ready_o          (ready0)
  );
  sirq_chan u_ch1 (
    .sys_clk_i        (sys_clk_i),
    .srst_i           (srst_i),
    .evt_i            (ev1),
    .route_i          (route1_q),
    .dma_done_i       (dma_done_i[1]),
    .dma_end_irq_en_i (dma_end_irq_en_i[1]),
    .dma_req_o        (dma_req[1]),
    .ready_o          (ready1)
  );
  assign gate = flags_q & enable_q & {ready1, ready0};

  // CPU request: level above CPU level, CPU enabled, nothing higher pending
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      irq_req_o   <= 2'h0;
      irq_level_o <= 3'h0;
      dma_req_o   <= 2'h0;
    end else begin
      dma_req_o <= dma_req;
      irq_req_o[0] <= |gate[2:0] && cpu_interrupt_enable_i && !higher_req_pending_i
                      && prio0_q > cpu_interrupt_level_i;
      irq_req_o[1] <= |gate[5:3] && cpu_interrupt_enable_i && !higher_req_pending_i
                      && prio1_q > cpu_interrupt_level_i;
      irq_level_o <= (|gate[2:0] && prio0_q >= prio1_q) || !(|gate[5:3]) ? prio0_q : prio1_q;
    end
  end

  // Ready and clock pin directions follow pin function, enable and mode; data out follows pin function alone, data in is never driven
  generate
    for (genvar c = 0; c < 2; c++) begin : g_pin
      logic       en;
      logic [1:0] md;
      assign en = ctrl_q[`SIRQ_CTL_TXEN0 + 2*c] | ctrl_q[`SIRQ_CTL_RXEN0 + 2*c];
      assign md = ctrl_q[`SIRQ_CTL_MODE0 + 2*c +: 2];
      always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
          sync_ready_pin_o.oe[c]      <= 1'b0;
          serial_clock_pin_o.oe[c]    <= 1'b0;
          sync_ready_pin_o.o[c]       <= 1'b0;
          serial_clock_pin_o.o[c]     <= 1'b0;
          serial_data_in_pin_oe_o[c]  <= 1'b0;
          serial_data_out_pin_oe_o[c] <= 1'b0;
        end else begin
          sync_ready_pin_o.oe[c]   <= ctrl_q[`SIRQ_CTL_PFS] && en
                                      && md == `SIRQ_MODE_SLAVE;
          serial_clock_pin_o.oe[c] <= ctrl_q[`SIRQ_CTL_PFS] && en
                                      && md == `SIRQ_MODE_MASTER;
          sync_ready_pin_o.o[c]       <= 1'b0;
          serial_clock_pin_o.o[c]     <= 1'b1;
          serial_data_in_pin_oe_o[c]  <= 1'b0;
          serial_data_out_pin_oe_o[c] <= ctrl_q[`SIRQ_CTL_PFS];
        end
      end
    end
  endgenerate

  // Read mux
  always_comb begin
    rd_d = 8'h00;
    hit  = 1'b1;
    case (avs_address_i)
      `SIRQ_OFF_PRIO:   rd_d = {1'b0, prio0_q, 4'h0};
      `SIRQ_OFF_PRIO1:  rd_d = {5'h00, prio1_q};
      `SIRQ_OFF_ENABLE: rd_d = {2'h0, enable_q};
      `SIRQ_OFF_FLAGS:  rd_d = {2'h0, flags_q};
      `SIRQ_OFF_ROUTE0: rd_d = {route0_q, 6'h00};
      `SIRQ_OFF_ROUTE1: rd_d = {6'h00, route1_q};
      `SIRQ_OFF_CTRL:   rd_d = ctrl_q[7:0];
      `SIRQ_OFF_STATUS: rd_d = {4'h0, dma_req, irq_req_o};
      default:          hit  = 1'b0;
    endcase
  end
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      avs_readdata_o <= 32'h0000_0000;
      avs_response_o <= 2'h0;
    end else begin
      avs_readdata_o <= (avs_address_i == `SIRQ_OFF_CTRL) ?
                        {22'h000000, ctrl_q} : {24'h000000, rd_d};
      avs_response_o <= hit ? 2'h0 : 2'h2;
    end
  end

  // Checks
  AST_FLAG_SET: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    set_evt[0] |=> flags_q[0]) else $error("flag not set");
  AST_ERR_FULL: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    evt0_i.err |=> flags_q[1]) else $error("full not raised");
  AST_NO_HW_CLR: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    flags_q[2] && !wr |=> flags_q[2]) else $error("flag cleared");
  AST_IRQ_GATE: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    irq_req_o[0] |-> $past(cpu_interrupt_enable_i)) else $error("irq ungated");
  AST_WAIT: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    avs_read_i && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("no ack");
  AST_RDY_DIR: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    sync_ready_pin_o.oe[0] |-> $past(ctrl_q[`SIRQ_CTL_PFS])) else $error("ready dir");
  AST_CLK_DIR: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !en_any0() |=> !serial_clock_pin_o.oe[0]) else $error("clock dir");
  AST_ENA_RST: assert property (@(posedge sys_clk_i)
    srst_i |=> enable_q == 6'h00) else $error("enable reset");
  function automatic logic en_any0();
    return ctrl_q[`SIRQ_CTL_TXEN0] | ctrl_q[`SIRQ_CTL_RXEN0];
  endfunction : en_any0
endmodule : sirq_top
`default_nettype wire

// ---- test/sirq_dma_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module sirq_dma_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Requests and settings
  input  wire logic [1:0] dma_req_i,
  input  wire logic [3:0] dly_i,
  input  wire logic [1:0] end_en_i,
  // Completion
  output logic [1:0]      dma_done_o,
  output logic [1:0]      dma_end_irq_en_o
);
  logic [3:0] cnt_q [2];
  logic [1:0] served_q;
  // End interrupt enable held on the transfer side
  assign dma_end_irq_en_o = end_en_i;
  // One completion pulse per request, after a set delay
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < 2; c++) begin
      dma_done_o[c] <= 1'b0;
      if (rst_i || !dma_req_i[c]) begin
        cnt_q[c]    <= 4'h0;
        served_q[c] <= 1'b0;
      end else if (!served_q[c]) begin
        if (cnt_q[c] == dly_i) begin
          dma_done_o[c] <= 1'b1;
          served_q[c]   <= 1'b1;
        end else begin
          cnt_q[c] <= cnt_q[c] + 4'h1;
        end
      end
    end
  end
endmodule : sirq_dma_model
`default_nettype wire

// ---- test/sirq_top_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sirq_cfg.svh"
module sirq_top_tb_top;
  import sirq_pkg::*;
  typedef struct {int ch; int fac; logic en; logic ie; logic [2:0] pr; logic [2:0] lv;
                  logic hi; logic ex;} sirq_row_t;
  logic        clk, srst, rd, wr, ie, hi, wreq;
  logic [19:0] adr;
  logic [31:0] wd, rdat, q;
  logic [1:0]  resp, r, dreq, irq, ddone, dend, din_oe, dout_oe, end_en;
  logic [2:0]  lvl, ilvl;
  logic [3:0]  dly;
  sirq_evt_t   ev0, ev1;
  sirq_pin_t   rdy_pin, clk_pin;
  int          err_count, total_checks, b;
  sirq_row_t   rows [8] = '{'{0,0,1,1,5,2,0,1}, '{0,1,0,1,5,2,0,0}, '{0,2,1,0,5,2,0,0},
    '{1,0,1,1,3,3,0,0}, '{1,1,1,1,4,3,0,1}, '{1,2,1,1,7,0,1,0}, '{1,2,1,1,7,6,0,1},
    '{0,2,1,1,0,0,0,0}};
  sirq_top dut (.sys_clk_i(clk), .srst_i(srst), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .avs_response_o(resp), .evt0_i(ev0), .evt1_i(ev1),
    .cpu_interrupt_enable_i(ie), .cpu_interrupt_level_i(lvl), .higher_req_pending_i(hi),
    .dma_done_i(ddone), .dma_end_irq_en_i(dend), .dma_req_o(dreq), .irq_req_o(irq),
    .irq_level_o(ilvl), .sync_ready_pin_o(rdy_pin), .serial_clock_pin_o(clk_pin),
    .serial_data_in_pin_oe_o(din_oe), .serial_data_out_pin_oe_o(dout_oe));
  sirq_dma_model pm (.clk_i(clk), .rst_i(srst), .dma_req_i(dreq), .dly_i(dly),
    .end_en_i(end_en), .dma_done_o(ddone), .dma_end_irq_en_o(dend));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [19:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wd  <= d;
    rd  <= !w;
    wr  <= w;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    chk("waitrequest", 32'h0, {31'h0, wreq});
    q = rdat;
    r = resp;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic rdc(input logic [19:0] a, input logic [31:0] e, input string n);
    bus(1'b0, a, 32'h0);
    chk(n, e, q);
  endtask : rdc
  task automatic pulse(input int ch, input int fac);
    @(posedge clk);
    if (ch == 0) ev0 <= sirq_evt_t'(3'b100 >> fac);
    else ev1 <= sirq_evt_t'(3'b100 >> fac);
    @(posedge clk);
    ev0 <= '0;
    ev1 <= '0;
    repeat (3) @(posedge clk);
  endtask : pulse
  task automatic cpu(input logic e, input logic [2:0] l, input logic h);
    @(posedge clk);
    ie  <= e;
    lvl <= l;
    hi  <= h;
    repeat (3) @(posedge clk);
  endtask : cpu
  task automatic pins(input logic [1:0] er, input logic [1:0] ec, input logic [1:0] eo);
    repeat (2) @(posedge clk);
    chk("ready oe", 32'(er), 32'(rdy_pin.oe));
    chk("clock oe", 32'(ec), 32'(clk_pin.oe));
    chk("data out oe", 32'(eo), 32'(dout_oe));
    chk("data in oe", 32'h0, 32'(din_oe));
  endtask : pins
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    final_report();
  end
  initial begin
    {srst, rd, wr, ie, hi, adr, wd, lvl, end_en} = '0;
    srst = 1'b1;
    ev0 = '0;
    ev1 = '0;
    dly = 4'h8;
    err_count = 0;
    total_checks = 0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rdc(`SIRQ_OFF_ENABLE, 32'h0, "enable reset");
    rdc(`SIRQ_OFF_CTRL, 32'h1, "ctrl reset");
    bus(1'b0, 20'h40270, 32'h0);
    chk("unmapped data", 32'h0, q);
    chk("unmapped resp", 32'h2, 32'(r));
    bus(1'b1, `SIRQ_OFF_FLAGS, 32'h3F);
    bus(1'b1, `SIRQ_OFF_ROUTE0, 32'h0);
    bus(1'b1, `SIRQ_OFF_ROUTE1, 32'h0);
    foreach (rows[i]) begin
      b = rows[i].ch * 3 + rows[i].fac;
      bus(1'b1, `SIRQ_OFF_PRIO, 32'(rows[i].pr) << 4);
      bus(1'b1, `SIRQ_OFF_PRIO1, 32'(rows[i].pr));
      rdc(`SIRQ_OFF_PRIO1, 32'(rows[i].pr), "priority");
      bus(1'b1, `SIRQ_OFF_ENABLE, 32'(rows[i].en) << b);
      cpu(rows[i].ie, rows[i].lv, rows[i].hi);
      pulse(rows[i].ch, rows[i].fac);
      rdc(`SIRQ_OFF_FLAGS, (32'h1 << b) | (rows[i].fac == 0 ? 32'h2 << b : 0), "flags");
      chk("irq", 32'(rows[i].ex) << rows[i].ch, 32'(irq));
      if (rows[i].ex) chk("irq level", 32'(rows[i].pr), 32'(ilvl));
      bus(1'b1, `SIRQ_OFF_FLAGS, 32'h3F);
      rdc(`SIRQ_OFF_FLAGS, 32'h0, "flags cleared");
    end
    bus(1'b1, `SIRQ_OFF_PRIO, 32'h50);
    bus(1'b1, `SIRQ_OFF_ENABLE, 32'h04);
    cpu(1'b0, 3'h0, 1'b0);
    pulse(0, 2);
    chk("irq masked", 32'h0, 32'(irq));
    cpu(1'b1, 3'h0, 1'b0);
    chk("irq unmasked", 32'h1, 32'(irq));
    rdc(`SIRQ_OFF_STATUS, 32'h1, "status");
    cpu(1'b0, 3'h0, 1'b0);
    cpu(1'b1, 3'h0, 1'b0);
    chk("irq again", 32'h1, 32'(irq));
    bus(1'b1, `SIRQ_OFF_CTRL, 32'h0);
    bus(1'b1, `SIRQ_OFF_FLAGS, 32'h24);
    rdc(`SIRQ_OFF_FLAGS, 32'h24, "rw set");
    bus(1'b1, `SIRQ_OFF_FLAGS, 32'h04);
    rdc(`SIRQ_OFF_FLAGS, 32'h04, "rw clear");
    bus(1'b1, `SIRQ_OFF_CTRL, 32'h1);
    bus(1'b1, `SIRQ_OFF_FLAGS, 32'h0);
    rdc(`SIRQ_OFF_FLAGS, 32'h04, "zero ignored");
    bus(1'b1, `SIRQ_OFF_FLAGS, 32'h04);
    rdc(`SIRQ_OFF_FLAGS, 32'h0, "one clears");
    bus(1'b1, `SIRQ_OFF_PRIO1, 32'h5);
    bus(1'b1, `SIRQ_OFF_ENABLE, 32'h3F);
    for (int i = 0; i < 4; i++) begin
      end_en <= (i % 2 == 0) ? 2'b11 : 2'b00;
      dly <= (i == 3) ? 4'h1 : 4'h8;
      bus(1'b1, `SIRQ_OFF_ROUTE0, (i < 2) ? 32'h40 << (i % 2) : 32'h0);
      bus(1'b1, `SIRQ_OFF_ROUTE1, (i < 2) ? 32'h0 : 32'h1 << (i % 2));
      pulse(i / 2, 1 + i % 2);
      if (i != 3) chk("dma req", 32'h1 << (i / 2), 32'(dreq));
      if (i != 3) chk("irq before done", 32'h0, 32'(irq));
      repeat (12) @(posedge clk);
      chk("irq after done", (i % 2 == 0) ? 32'h1 << (i / 2) : 32'h0, 32'(irq));
      bus(1'b1, `SIRQ_OFF_FLAGS, 32'h3F);
    end
    bus(1'b1, `SIRQ_OFF_CTRL, 32'h003);
    pins(2'b00, 2'b00, 2'b11);
    bus(1'b1, `SIRQ_OFF_CTRL, 32'h043);
    pins(2'b00, 2'b00, 2'b11);
    bus(1'b1, `SIRQ_OFF_CTRL, 32'h067);
    pins(2'b01, 2'b10, 2'b11);
    bus(1'b1, `SIRQ_OFF_CTRL, 32'h043);
    pins(2'b00, 2'b00, 2'b11);
    bus(1'b1, `SIRQ_OFF_CTRL, 32'h001);
    pins(2'b00, 2'b00, 2'b00);
    pulse(0, 0);
    chk("irq before reset", 32'h1, 32'(irq));
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk("irq after reset", 32'h0, 32'(irq));
    rdc(`SIRQ_OFF_ENABLE, 32'h0, "enable after reset");
    final_report();
  end
endmodule : sirq_top_tb_top
`default_nettype wire
